//--- logic/rrc_core.sv
// execution core: decode, ALU, shifter, exchange, register file, buses
// assumes code words arrive every clock; memory answers a load in the
// same cycle its address is driven
`timescale 1ns/1ps
`default_nettype none
module rrc_core (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire rrc_pkg::rrc_instr_t CODE,
  input  wire logic [31:0]         D_IN,
  output logic [31:0]              D_OUT,
  output logic                     D_OE,
  input  wire logic [31:0]         AD_IN,
  output logic [31:0]              AD_OUT,
  output logic                     AD_OE,
  output logic [3:0]               BYTE_WRITE_SELECTS_N,
  output logic                     COND
);
  import rrc_pkg::*;

  rrc_core_st_t q;
  rrc_core_st_t n;
  rrc_instr_t   i;
  rrc_md_req_t  md_req;
  rrc_md_res_t  md_res;
  logic [31:0]  a_val;
  logic [31:0]  b_val;
  logic [31:0]  c_val;
  logic [31:0]  imm;
  logic [31:0]  b_opnd;
  logic         use_imm;
  logic         sub;
  logic         cin;
  logic [32:0]  sum;
  logic [31:0]  lg_res;
  logic [31:0]  xc_res;
  logic [4:0]   xc_size;
  logic [4:0]   xc_mask;

  ////////////////////////////////////////////////////////////////////////
  // upper four registers map to the alternate bank when bank is set
  function automatic logic [5:0] phys(input logic [4:0] r,
                                      input logic bank);
    if (bank && r[4:2] == BANKED_TOP) begin
      return {ALT_BASE_HI, r[1:0]};
    end
    return {1'b0, r};
  endfunction

  function automatic logic [5:0] lead_zeros(input logic [31:0] v);
    logic [5:0] cnt;
    cnt = 6'h20;
    for (int k = 0; k < 32; k++) begin
      if (v[k]) begin
        cnt = 6'(31 - k);
      end
    end
    return cnt;
  endfunction

  // misaligned offsets read the lane that the low bits still select
  function automatic logic [31:0] align_load(input logic [31:0] w,
                                             input logic [1:0] off,
                                             input logic [1:0] sz);
    logic [31:0] sh;
    sh = '0;
    case (sz)
      SZ_HALF: begin
        sh = w >> {off[1], 4'h0};
        return {16'h0, sh[15:0]};
      end
      SZ_BYTE: begin
        sh = w >> {off, 3'h0};
        return {24'h0, sh[7:0]};
      end
      default: return w;
    endcase
  endfunction

  // undefined alignments write no lane, except a halfword at offset 1, which writes lanes 1:0
  function automatic logic [3:0] lane_mask(input logic [1:0] off,
                                           input logic [1:0] sz);
    case (sz)
      SZ_WORD: return (off == 2'h0) ? 4'hF : 4'h0;
      SZ_HALF: return (off == 2'h3) ? 4'h0 : (off[1] ? 4'hC : 4'h3);
      SZ_BYTE: return 4'(4'h1 << off);
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // operand fetch: three read ports plus the write port below
  assign i = q.ir;
  assign a_val = q.rf[phys(i.ra, q.bank)];
  assign b_val = q.rf[phys(i.rb, q.bank)];
  assign c_val = q.rf[phys(i.rc, q.bank)];
  assign imm = {22'h0, i.rb, i.xop, i.csel};
  assign use_imm = (i.op == OP_ADDI) || (i.op == OP_SUBI);
  assign b_opnd = use_imm ? imm : b_val;

  // subtract adds the inverse; stored carry only on request, else borrow
  assign sub = (i.op == OP_SUBI) ||
               (i.op == OP_ARITH && i.xop[XA_SUB_BIT]);
  assign cin = (i.op == OP_ARITH && i.xop[XA_CARRY_BIT]) ? q.carry : sub;
  assign sum = {1'b0, a_val} + {1'b0, sub ? ~b_opnd : b_opnd} +
               {32'h0, cin};

  assign xc_size = 5'(5'h2 << i.xop[1:0]);
  assign xc_mask = (i.xop[XX_SWAP_BIT] ? xc_size : 5'h0) ^
                   (i.xop[XX_REV_BIT] ? 5'(xc_size - 5'h1) : 5'h0);

  // each logic result bit picks from the extension code as a truth table
  generate
    for (genvar k = 0; k < 32; k++) begin : g_bit
      assign lg_res[k] = i.xop[{a_val[k], b_val[k]}];
      assign xc_res[k] = a_val[5'(k) ^ xc_mask];
    end
  endgenerate

  rrc_muldiv u_muldiv (
    .CLK_SYS (CLK_SYS),
    .RST_N   (RST_N),
    .REQ     (md_req),
    .RES     (md_res)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [31:0] res;
    logic        wr_en;
    logic [4:0]  wr_reg;
    logic        set_cond;
    logic [31:0] fmask;
    logic [4:0]  amt;
    logic [31:0] ea;
    logic [3:0]  lanes;
    res = '0;
    wr_en = 1'b0;
    wr_reg = i.rc;
    set_cond = 1'b0;
    fmask = '0;
    amt = b_val[SH_AMT_LO +: 5];
    ea = a_val + b_val;
    lanes = '0;
    n = q;
    n.ir = CODE;
    n.ad_oe = 1'b0;
    n.d_oe = q.st_hold;
    n.st_hold = 1'b0;
    n.bws_n = BWS_IDLE;
    md_req = '0;
    // top sequencer byte is never decoded here
    case (i.op)
      OP_ARITH, OP_ADDI, OP_SUBI: begin
        res = sum[31:0];
        n.carry = sum[32];
        wr_en = 1'b1;
        set_cond = 1'b1;
      end
      OP_LOGIC: begin
        res = lg_res;
        wr_en = 1'b1;
        set_cond = 1'b1;
      end
      OP_SHIFT: begin
        if (b_val[SH_LEN_LO +: 5] == 5'h0) begin
          fmask = '1;
        end else begin
          fmask = (32'h1 << b_val[SH_LEN_LO +: 5]) - 32'h1;
        end
        case (i.xop)
          XS_SHL: res = a_val << amt;
          XS_SHR: res = a_val >> amt;
          XS_EXT: res = (a_val >> amt) & fmask;
          XS_DEP: res = (c_val & ~(fmask << amt)) |
                        ((a_val & fmask) << amt);
          XS_MRG: res = (a_val & q.am) | (b_val & ~q.am);
          default: res = a_val;
        endcase
        wr_en = 1'b1;
        set_cond = 1'b1;
      end
      OP_XCHG: begin
        res = xc_res;
        wr_en = 1'b1;
        set_cond = 1'b1;
      end
      OP_PRIO: begin
        res = {26'h0, lead_zeros(a_val)};
        wr_en = 1'b1;
        set_cond = 1'b1;
      end
      OP_MUL: begin
        md_req.mul = !md_res.busy;
        md_req.a = a_val;
        md_req.b = b_val;
      end
      OP_DIV: begin
        md_req.div = !md_res.busy;
        md_req.a = a_val;
        md_req.dividend = {q.am, q.al};
      end
      OP_PROD: begin
        case (i.xop)
          XP_RD_AM: begin
            res = q.am;
            wr_en = 1'b1;
          end
          XP_RD_AL: begin
            res = q.al;
            wr_en = 1'b1;
          end
          XP_WR_AM: begin
            // the running unit owns am and al until it finishes
            if (!md_res.busy) begin
              n.am = a_val;
            end
          end
          XP_WR_AL: begin
            if (!md_res.busy) begin
              n.al = a_val;
            end
          end
          default: res = '0;
        endcase
      end
      OP_ADR: begin
        // address is driven next cycle, while the load or store behind it executes
        n.adr = (i.xop[1:0] == AM_POST) ? a_val : ea;
        n.adr_size = i.xop[3:2];
        n.ad_out = n.adr;
        n.ad_oe = 1'b1;
        if (i.xop[1:0] != AM_INDEX) begin
          res = ea;
          wr_reg = i.ra;
          wr_en = 1'b1;
        end
      end
      OP_LOAD: begin
        res = align_load(D_IN, q.adr[1:0], q.adr_size);
        wr_en = 1'b1;
      end
      OP_STORE: begin
        // a store right behind a store is dropped: the data bus is
        // still held by the first one
        if (!q.st_hold) begin
          case (q.adr_size)
            SZ_HALF: n.d_out = {2{a_val[15:0]}};
            SZ_BYTE: n.d_out = {4{a_val[7:0]}};
            default: n.d_out = a_val;
          endcase
          lanes = lane_mask(q.adr[1:0], q.adr_size);
          n.bws_n = ~lanes;
          n.d_oe = 1'b1;
          n.st_hold = 1'b1;
        end
      end
      OP_XFER: begin
        if (i.xop == XT_OUT) begin
          n.ad_out = a_val;
          n.ad_oe = 1'b1;
        end else if (i.xop == XT_IN) begin
          res = AD_IN;
          wr_en = 1'b1;
        end
      end
      OP_SWAP: begin
        // toggling the select exchanges both banks in a single step
        n.bank = ~q.bank;
      end
      default: res = '0;
    endcase
    if (wr_en) begin
      n.rf[phys(wr_reg, q.bank)] = res;
    end
    if (set_cond) begin
      n.cond = i.csel ? n.carry : (res == 32'h0);
    end
    // a finishing multiply or divide owns the product registers
    if (md_res.done) begin
      n.am = md_res.hi;
      n.al = md_res.lo;
    end
  end

  // one register stage holds every piece of architectural state
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q <= CORE_RESET;
    end else begin
      q <= n;
    end
  end

  assign D_OUT = q.d_out;
  assign D_OE = q.d_oe;
  assign AD_OUT = q.ad_out;
  assign AD_OE = q.ad_oe;
  assign BYTE_WRITE_SELECTS_N = q.bws_n;
  assign COND = q.cond;

endmodule
`default_nettype wire

//--- logic/rrc_pkg.sv
// constants, instruction layout and state types of the raster execution core
// assumes one 200 MHz clock and a synchronous active-low reset
// Overview of operation
// - ALU adds, subtracts, sixteen logic functions, address generation
// - every ALU operation finishes in one cycle, one instruction per cycle
// - shifter moves 0 to 31 bits either way for deposit, extract, merge
// - bitwise merge combines fields of two sources into one word
// - perfect exchange swaps or reverses 2, 4, 8 or 16 bit fields
// - priority encode counts zeros before the first one bit
// - multiply gives 64-bit product of two 32-bit words in eight cycles
// - divide 64 by 32 gives quotient and remainder after twenty cycles
// - multiply and divide run while other instructions keep executing
// - register file holds thirty-six 32-bit words through four ports
// - registers 28 to 31 have a second bank for interrupt code
// - three separate 32-bit buses: code, data and data address
// - code bus word is shared with the code sequencer
// - data bus allows one load each cycle or one store per two
// - each byte lane of a store has its own write select
// - address bus carries addresses and data words, one per cycle
// - loads and stores are delayed and overlap other instructions
// - a memory access is address generation then a data transfer
// - indexed, pre and post increment; word, halfword or byte access
// - decoder reads three register fields, opcode, extension, condition
// - an immediate from the instruction may replace one operand
// - top eight instruction bits belong to the sequencer, ignored here
// - low two address bits pick byte or halfword; misaligned is undefined
// - swap exchanges the two banks of registers 28 to 31 in one cycle
// - write selects carry lanes only during a store, high otherwise
package rrc_pkg;

  localparam int unsigned NUM_REGS  = 36;
  localparam int unsigned MUL_CYCLES = 8;
  localparam int unsigned DIV_CYCLES = 20;
  localparam int unsigned DIV_BITS_PER_CYCLE = 2;
  localparam int unsigned MUL_BITS_PER_CYCLE = 4;
  localparam logic [3:0] BWS_IDLE = 4'hF;
  localparam logic [2:0] BANKED_TOP = 3'h7;
  localparam logic [3:0] ALT_BASE_HI = 4'h8;

  typedef enum logic [3:0] {
    OP_NOP, OP_ARITH, OP_ADDI, OP_SUBI, OP_LOGIC, OP_SHIFT, OP_XCHG,
    OP_PRIO, OP_MUL, OP_DIV, OP_PROD, OP_ADR, OP_LOAD, OP_STORE,
    OP_XFER, OP_SWAP
  } rrc_op_t;

  // arithmetic extension: bit 0 subtract, bit 1 take carry in
  localparam int unsigned XA_SUB_BIT = 0;
  localparam int unsigned XA_CARRY_BIT = 1;
  // shifter extension codes
  localparam logic [3:0] XS_SHL = 4'h0;
  localparam logic [3:0] XS_SHR = 4'h1;
  localparam logic [3:0] XS_EXT = 4'h2;
  localparam logic [3:0] XS_DEP = 4'h3;
  localparam logic [3:0] XS_MRG = 4'h4;
  // exchange extension: size select, swap bit, reverse bit
  localparam int unsigned XX_SWAP_BIT = 2;
  localparam int unsigned XX_REV_BIT = 3;
  // product register moves
  localparam logic [3:0] XP_RD_AM = 4'h0;
  localparam logic [3:0] XP_RD_AL = 4'h1;
  localparam logic [3:0] XP_WR_AM = 4'h2;
  localparam logic [3:0] XP_WR_AL = 4'h3;
  // address modes in extension bits 1:0, access size in bits 3:2
  localparam logic [1:0] AM_INDEX = 2'h0;
  localparam logic [1:0] AM_PRE = 2'h1;
  localparam logic [1:0] AM_POST = 2'h2;
  localparam logic [1:0] SZ_WORD = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_BYTE = 2'h2;
  // address bus transfers
  localparam logic [3:0] XT_OUT = 4'h0;
  localparam logic [3:0] XT_IN = 4'h1;
  // shift operand: amount in bits 4:0, field length in 9:5 (0 means 32)
  localparam int unsigned SH_AMT_LO = 0;
  localparam int unsigned SH_LEN_LO = 5;

  typedef struct packed {
    logic [7:0] seq_op;
    rrc_op_t    op;
    logic [4:0] rc;
    logic [4:0] ra;
    logic [4:0] rb;
    logic [3:0] xop;
    logic       csel;
  } rrc_instr_t;

  typedef struct packed {
    logic        mul;
    logic        div;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] dividend;
  } rrc_md_req_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] hi;
    logic [31:0] lo;
  } rrc_md_res_t;

  typedef struct packed {
    logic        busy;
    logic        is_div;
    logic        done;
    logic [4:0]  cnt;
    logic [63:0] acc;
    logic [31:0] opb;
  } rrc_md_st_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][31:0] rf;
    rrc_instr_t  ir;
    logic [31:0] am;
    logic [31:0] al;
    logic [31:0] adr;
    logic [1:0]  adr_size;
    logic        carry;
    logic        bank;
    logic [31:0] d_out;
    logic        d_oe;
    logic [31:0] ad_out;
    logic        ad_oe;
    logic [3:0]  bws_n;
    logic        cond;
    logic        st_hold;
  } rrc_core_st_t;

  localparam rrc_core_st_t CORE_RESET = '{bws_n: BWS_IDLE, default: '0};
  localparam rrc_md_st_t MD_RESET = '{default: '0};

endpackage

//--- logic/rrc_muldiv.sv
// iterative multiply/divide unit beside the main ALU
// assumes start requests only while idle; results stay in acc until next start
`timescale 1ns/1ps
`default_nettype none
module rrc_muldiv (
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  input  wire rrc_pkg::rrc_md_req_t REQ,
  output var  rrc_pkg::rrc_md_res_t RES
);
  import rrc_pkg::*;

  rrc_md_st_t q;
  rrc_md_st_t d;

  // one restoring step; the 33-bit compare covers a remainder near 2^32
  function automatic logic [63:0] div_step(input logic [63:0] acc,
                                           input logic [31:0] dv);
    logic [64:0] t;
    t = {acc, 1'b0};
    if (t[64:32] >= {1'b0, dv}) begin
      t[64:32] = t[64:32] - {1'b0, dv};
      t[0] = 1'b1;
    end
    return t[63:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [35:0] part;
    logic [35:0] upper;
    part = '0;
    upper = '0;
    d = q;
    d.done = 1'b0;
    if (q.busy) begin
      if (!q.is_div) begin
        part = q.opb * q.acc[3:0];
        upper = {4'h0, q.acc[63:32]} + part;
        d.acc = {upper, q.acc[31:4]};
      end else if (q.cnt < 5'(32 / DIV_BITS_PER_CYCLE)) begin
        d.acc = div_step(div_step(q.acc, q.opb), q.opb);
      end
      d.cnt = q.cnt + 5'h1;
      if ((!q.is_div && q.cnt == 5'(MUL_CYCLES - 1)) ||
          (q.is_div && q.cnt == 5'(DIV_CYCLES - 1))) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end else if (REQ.mul || REQ.div) begin
      d.busy = 1'b1;
      d.is_div = REQ.div;
      d.cnt = '0;
      d.opb = REQ.div ? REQ.a : REQ.b;
      d.acc = REQ.div ? REQ.dividend : {32'h0, REQ.a};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      q <= MD_RESET;
    end else begin
      q <= d;
    end
  end

  // remainder in hi, quotient in lo after a divide
  assign RES.busy = q.busy;
  assign RES.done = q.done;
  assign RES.hi = q.acc[63:32];
  assign RES.lo = q.acc[31:0];

endmodule
`default_nettype wire

//--- verif/rrc_core_monitor.sv
// port checker of the execution core: store, address and condition timing
// assumes it is bound onto rrc_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rrc_core_monitor (
  input wire logic                CLK_SYS,
  input wire logic                RST_N,
  input wire rrc_pkg::rrc_instr_t CODE,
  input wire logic [31:0]         D_OUT,
  input wire logic                D_OE,
  input wire logic                AD_OE,
  input wire logic [3:0]          BYTE_WRITE_SELECTS_N,
  input wire logic                COND
);
  import rrc_pkg::*;
  logic sel_on;
  assign sel_on = BYTE_WRITE_SELECTS_N != BWS_IDLE;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_store;
    CODE.op == OP_STORE;
  endsequence
  sequence s_data_held;
    D_OE && $stable(D_OUT);
  endsequence
  a_store_drives: assert property (s_store |-> ##2 D_OE)
    else $error("store did not drive the data bus");
  a_data_two: assert property ($rose(D_OE) |=> s_data_held)
    else $error("store data not held for two cycles");
  a_oe_cause: assert property (D_OE |->
      $past(CODE.op, 2) == OP_STORE || $past(CODE.op, 3) == OP_STORE)
    else $error("data bus driven without a store");
  a_select_pulse: assert property (sel_on |=> !sel_on)
    else $error("write selects low for more than one cycle");
  a_select_cause: assert property (sel_on |->
      D_OE && $past(CODE.op, 2) == OP_STORE)
    else $error("write selects low outside a store");
  a_adr_drives: assert property (CODE.op == OP_ADR |-> ##2 AD_OE)
    else $error("address not driven after address generation");
  a_addr_cause: assert property (AD_OE |->
      $past(CODE.op, 2) inside {OP_ADR, OP_XFER})
    else $error("address bus driven without a cause");
  a_cond_hold: assert property ($changed(COND) && $past(RST_N) |->
      $past(CODE.op, 2) inside {OP_ARITH, OP_ADDI, OP_SUBI, OP_LOGIC,
                                OP_SHIFT, OP_XCHG, OP_PRIO})
    else $error("condition changed after a non-setting op");
endmodule
bind rrc_core rrc_core_monitor u_mon (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CODE(CODE), .D_OUT(D_OUT),
  .D_OE(D_OE), .AD_OE(AD_OE),
  .BYTE_WRITE_SELECTS_N(BYTE_WRITE_SELECTS_N), .COND(COND));
`default_nettype wire

//--- verif/rrc_mem_model.sv
// sixteen-word data memory answering the core's loads and stores
// assumes a load wants its word in the cycle the address stands
`timescale 1ns/1ps
`default_nettype none
module rrc_mem_model (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic [31:0] AD_OUT,
  input  wire logic        AD_OE,
  input  wire logic [31:0] D_OUT,
  input  wire logic [3:0]  BYTE_WRITE_SELECTS_N,
  output logic [31:0]      D_IN
);
  logic [15:0][31:0] mem;
  logic [31:0]       adr_q;
  logic [31:0]       last_q = 32'h0;
  // bus not answering toggles, so a stale sample cannot pass
  assign D_IN = AD_OE ? mem[AD_OUT[5:2]] : ~last_q;
  always @(posedge CLK_SYS) begin
    last_q <= D_IN;
    if (AD_OE)
      adr_q <= AD_OUT;
    if (!RST_N)
      for (int i = 0; i < 16; i++)
        mem[i] <= {4{8'(i + 1)}};
    else
      for (int k = 0; k < 4; k++)
        if (!BYTE_WRITE_SELECTS_N[k])
          mem[adr_q[5:2]][8*k +: 8] <= D_OUT[8*k +: 8];
  end
endmodule
`default_nettype wire

//--- verif/rrc_core_bench.sv
// self-checking bench of the execution core with a data memory model
// assumes the monitor is bound in; registers are read over the address bus
`timescale 1ns/1ps
`default_nettype none
module rrc_core_bench;
  import rrc_pkg::*;
  logic        clk_sys, rst_n, d_oe, ad_oe, cond;
  logic [31:0] d_in, d_out, ad_in, ad_out;
  logic [3:0]  bws_n, sel_seen;
  rrc_instr_t  code;
  int          err_count = 0;
  int          n_tests = 0;
  int          n_sel = 0;
  rrc_core u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CODE(code),
    .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .AD_IN(ad_in),
    .AD_OUT(ad_out), .AD_OE(ad_oe), .BYTE_WRITE_SELECTS_N(bws_n),
    .COND(cond));
  rrc_mem_model u_mem (.CLK_SYS(clk_sys), .RST_N(rst_n), .AD_OUT(ad_out),
    .AD_OE(ad_oe), .D_OUT(d_out), .BYTE_WRITE_SELECTS_N(bws_n),
    .D_IN(d_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (bws_n !== BWS_IDLE) begin
    n_sel++;
    sel_seen = bws_n;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // top byte is sequencer opcode, filled to show it is ignored
  function automatic rrc_instr_t mk(rrc_op_t op, logic [4:0] rc, ra, rb,
                                    logic [3:0] x);
    mk = '{8'hA5, op, rc, ra, rb, x, 1'b0};
  endfunction
  task automatic run(input rrc_instr_t i);
    @(posedge clk_sys);
    code <= i;
  endtask
  task automatic nops(input int n);
    repeat (n) run(mk(OP_NOP, 0, 0, 0, 0));
  endtask
  task automatic put(input logic [4:0] r, input logic [31:0] v);
    run(mk(OP_XFER, r, 0, 0, XT_IN));
    ad_in <= v;
    nops(1);
  endtask
  task automatic get(input logic [4:0] r, input logic [31:0] e);
    run(mk(OP_XFER, 0, r, 0, XT_OUT));
    nops(2);
    #1 chk32(ad_out, e);
  endtask
  task automatic st(input logic [3:0] x, input logic [4:0] rb,
                    input logic [3:0] es);
    sel_seen = BWS_IDLE;
    run(mk(OP_ADR, 0, 1, rb, x));
    run(mk(OP_STORE, 0, 3, 0, 0));
    nops(3);
    #1 chk32({28'h0, sel_seen}, {28'h0, es});
  endtask
  task automatic ld(input logic [3:0] x, input logic [4:0] ra, rb,
                    input logic [31:0] e);
    run(mk(OP_ADR, 0, ra, rb, x));
    run(mk(OP_LOAD, 6, 0, 0, 0));
    get(6, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_alu;
    put(1, 32'hFFFFFFFE);
    put(2, 32'h2);
    run(mk(OP_ARITH, 3, 1, 2, 4'h0));
    run(mk(OP_ARITH, 4, 3, 2, 4'h1));
    run(mk(OP_ADDI, 5, 1, 5'h1F, 4'hF));
    run(mk(OP_ARITH, 7, 2, 2, 4'h2));
    run(mk(OP_SUBI, 6, 2, 0, 4'h1));
    nops(2);
    #1 chk32({31'h0, cond}, 32'h1);
    get(7, 32'h5);
    get(3, 32'h0);
    get(4, 32'hFFFFFFFE);
    get(5, 32'h3FC);
    get(6, 32'h0);
  endtask
  task automatic t_logic;
    logic [31:0] e;
    put(1, 32'h0000FFFF);
    put(2, 32'h00FF00FF);
    for (int f = 0; f < 16; f++) begin
      for (int k = 0; k < 32; k++)
        e[k] = f[{k < 16, !k[3]}];
      run(mk(OP_LOGIC, 3, 1, 2, f[3:0]));
      get(3, e);
    end
  endtask
  task automatic t_shift;
    put(1, 32'h40000001);
    put(2, 32'd31);
    put(4, 32'd30);
    put(7, 32'd0);
    put(8, 32'hFFFF0000);
    put(10, 32'h1234ABCD);
    put(11, 32'h104);
    put(13, 32'hFFFF0000);
    run(mk(OP_SHIFT, 12, 10, 11, XS_EXT));
    run(mk(OP_SHIFT, 13, 10, 11, XS_DEP));
    get(12, 32'hBC);
    get(13, 32'hFFFF0CD0);
    run(mk(OP_SHIFT, 3, 1, 2, XS_SHL));
    run(mk(OP_SHIFT, 5, 1, 4, XS_SHR));
    run(mk(OP_SHIFT, 6, 1, 7, XS_SHL));
    run(mk(OP_PROD, 0, 8, 0, XP_WR_AM));
    run(mk(OP_SHIFT, 9, 1, 10, XS_MRG));
    get(3, 32'h80000000);
    get(5, 32'h1);
    get(6, 32'h40000001);
    get(9, 32'h4000ABCD);
  endtask
  task automatic t_xchg;
    logic [31:0] v, e;
    int          s, j;
    v = 32'h12345678;
    put(1, v);
    for (int m = 4; m < 16; m++) begin
      s = 2 << m[1:0];
      for (int i = 0; i < 32; i++) begin
        j = m[3] ? s - 1 - i % s : i % s;
        e[i] = v[((i / s) ^ m[2]) * s + j];
      end
      run(mk(OP_XCHG, 2, 1, 0, m[3:0]));
      get(2, e);
    end
  endtask
  task automatic t_prio;
    logic [31:0] pv [3] = '{32'h0, 32'h00010000, 32'h80000000};
    int          pe [3] = '{32, 15, 0};
    for (int i = 0; i < 3; i++) begin
      put(1, pv[i]);
      run(mk(OP_PRIO, 2, 1, 0, 0));
      get(2, pe[i]);
    end
  endtask
  task automatic t_muldiv;
    put(1, 32'hFFFFFFFF);
    put(2, 32'h12345678);
    run(mk(OP_MUL, 0, 1, 2, 0));
    run(mk(OP_MUL, 0, 2, 2, 0));
    run(mk(OP_ARITH, 3, 2, 2, 0));
    nops(6);
    run(mk(OP_PROD, 6, 0, 0, XP_RD_AM));
    run(mk(OP_PROD, 4, 0, 0, XP_RD_AM));
    run(mk(OP_PROD, 5, 0, 0, XP_RD_AL));
    get(6, 32'hFFFF0000);
    get(4, 32'h12345677);
    get(5, 32'hEDCBA988);
    get(3, 32'h2468ACF0);
    put(7, 32'h1);
    put(8, 32'h5);
    put(9, 32'h10);
    run(mk(OP_PROD, 0, 7, 0, XP_WR_AM));
    run(mk(OP_PROD, 0, 8, 0, XP_WR_AL));
    run(mk(OP_DIV, 0, 9, 0, 0));
    nops(21);
    run(mk(OP_PROD, 4, 0, 0, XP_RD_AM));
    run(mk(OP_PROD, 5, 0, 0, XP_RD_AL));
    get(4, 32'h5);
    get(5, 32'h10000000);
  endtask
  task automatic t_mem;
    put(1, 32'h8);
    put(2, 32'h0);
    put(3, 32'hA1B2C3D4);
    put(4, 32'h1);
    put(5, 32'h2);
    put(7, 32'h8);
    st({SZ_WORD, AM_INDEX}, 2, 4'h0);
    st({SZ_BYTE, AM_INDEX}, 4, 4'hD);
    st({SZ_HALF, AM_INDEX}, 5, 4'h3);
    st({SZ_WORD, AM_INDEX}, 4, BWS_IDLE);
    ld({SZ_WORD, AM_INDEX}, 1, 2, 32'hC3D4D4D4);
    ld({SZ_BYTE, AM_INDEX}, 1, 4, 32'hD4);
    ld({SZ_BYTE, AM_POST}, 7, 4, 32'hD4);
    get(7, 32'h9);
    ld({SZ_HALF, AM_PRE}, 7, 4, 32'hC3D4);
    get(7, 32'hA);
    n_sel = 0;
    run(mk(OP_ADR, 0, 1, 2, 0));
    run(mk(OP_STORE, 0, 3, 0, 0));
    run(mk(OP_STORE, 0, 3, 0, 0));
    nops(4);
    chk32(n_sel, 32'h1);
  endtask
  task automatic t_swap;
    put(28, 32'hCAFE0001);
    run(mk(OP_SWAP, 0, 0, 0, 0));
    get(28, 32'h0);
    put(28, 32'h5);
    run(mk(OP_SWAP, 0, 0, 0, 0));
    get(28, 32'hCAFE0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    code = mk(OP_NOP, 0, 0, 0, 0);
    ad_in = 32'h0;
    sel_seen = BWS_IDLE;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk32({26'h0, bws_n, d_oe, ad_oe},
             {26'h0, BWS_IDLE, 2'b00});
    t_alu;
    t_logic;
    t_shift;
    t_xchg;
    t_prio;
    t_muldiv;
    t_mem;
    t_swap;
    end_of_test;
  end
  // a hang is cut short well inside the cycle budget
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
